// ==== src/mcc_config_top.sv ====
// Summary of operation
// R1 - Bit 10 selects sag/surge interrupt style
// R2 - Style 0: interrupt every programmed cycle count
// R3 - Style 1: interrupt on entry and on exit
// R4 - Settling code: 64, 128, 256 ms, none
// R5 - Bit 5 clears frequency accumulators and denominator
// R6 - Accumulator clear bit self-clears, reads zero
// R7 - Bits 3:2 route pin four source
// R8 - Bit 1 zero: pin three carries converter pulses
// R9 - Bit 1 one: pin three carries zero crossing
// R10 - Writing bit 0 starts a software reset
// R11 - Software reset bit clears itself
// R12 - Reserved bits read zero, ignore writes
// R13 - Accumulation idle until settling delay elapses
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module mcc_config_top #(
	parameter int unsigned T0_CYC = mcc_pkg::SETTLE_T0_CYC,
	parameter int unsigned T1_CYC = mcc_pkg::SETTLE_T1_CYC,
	parameter int unsigned T2_CYC = mcc_pkg::SETTLE_T2_CYC,
	parameter int unsigned CYC_W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic line_cycle,
	input wire logic sag_active,
	input wire logic surge_active,
	input wire logic pin_three_dfc_pulse,
	input wire logic pin_four_dfc_pulse,
	input wire logic event_indicator,
	input wire logic sample_ready_indicator,
	input wire logic [3:0] zero_cross_in,
	output logic pulse_pin_three,
	output logic pulse_pin_four,
	output logic accumulate_enable,
	output logic pulse_accumulator_clear,
	output logic software_reset_trigger,
	output logic irq
);
	import mcc_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	mcc_settle_if sif();

	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic req, wr_take;
	logic [7:0] addr_w;
	logic [31:0] be_mask;
	logic [15:0] wmask;

	logic [15:0] cfg_q, cfg_d;
	logic [1:0] zc_select_q, zc_select_d;
	logic [CYC_W-1:0] sag_lim_q, sag_lim_d;
	logic [CYC_W-1:0] surge_lim_q, surge_lim_d;
	logic [IRQ_W-1:0] en_q, en_d;
	logic [IRQ_W-1:0] status_q, status_d;
	logic [IRQ_W-1:0] clr_mask;
	logic [IRQ_W-1:0] evt;
	logic soft_rst_q, soft_rst_d;
	logic accclr_q, accclr_d;
	logic done_prev_q;
	logic pin3_q, pin3_d;
	logic pin4_q, pin4_d;
	logic [1:0] ds_evt;
	logic [1:0] ds_cond;
	logic ds_mode;

	// ------------------------------------------------------------
	// Bus handshake: one wait state on every access
	// ------------------------------------------------------------
	assign req = avs_read | avs_write;
	assign ack_d = req & ~ack_q;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_take = avs_write & ack_q;
	assign addr_w = {avs_address[7:2], 2'b00};
	assign avs_readdata = rdata_q;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			be_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
		end
	end

	assign wmask = be_mask[15:0] & CONFIG_WMASK; // R12

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		zc_select_d = zc_select_q;
		sag_lim_d = sag_lim_q;
		surge_lim_d = surge_lim_q;
		en_d = en_q;
		clr_mask = '0;
		soft_rst_d = 1'b0;
		accclr_d = 1'b0;
		if (wr_take) begin
			case (addr_w)
				OFF_CONFIG: begin
					cfg_d = (cfg_q & ~wmask) | (avs_writedata[15:0] & wmask); // R12
					soft_rst_d = avs_byteenable[0] & avs_writedata[BIT_SOFT_RST]; // R10
					accclr_d = avs_byteenable[0] & avs_writedata[BIT_ACC_CLR]; // R5
				end
				OFF_IRQ_CLEAR: begin
					clr_mask = avs_writedata[IRQ_W-1:0] & be_mask[IRQ_W-1:0];
				end
				OFF_IRQ_ENABLE: begin
					en_d = (en_q & ~be_mask[IRQ_W-1:0])
						| (avs_writedata[IRQ_W-1:0] & be_mask[IRQ_W-1:0]);
				end
				OFF_ZC_SELECT: begin
					if (avs_byteenable[0]) begin
						zc_select_d = avs_writedata[1:0];
					end
				end
				OFF_SAG_CYC: begin
					sag_lim_d = (sag_lim_q & ~be_mask[CYC_W-1:0])
						| (avs_writedata[CYC_W-1:0] & be_mask[CYC_W-1:0]);
				end
				OFF_SURGE_CYC: begin
					surge_lim_d = (surge_lim_q & ~be_mask[CYC_W-1:0])
						| (avs_writedata[CYC_W-1:0] & be_mask[CYC_W-1:0]);
				end
				default: begin
					cfg_d = cfg_q;
				end
			endcase
		end
		if (soft_rst_q) begin
			cfg_d = CONFIG_RESET; // R10
			zc_select_d = ZC_SELECT_RESET;
			sag_lim_d = CYC_W'(CYC_LIMIT_RESET);
			surge_lim_d = CYC_W'(CYC_LIMIT_RESET);
			en_d = IRQ_RESET;
			accclr_d = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = rdata_q;
		if (req & ~ack_q) begin
			case (addr_w)
				OFF_CONFIG: rdata_d = {16'h0000, cfg_q}; // R6 R11 R12
				OFF_IRQ_STATUS: rdata_d = 32'(status_q);
				OFF_IRQ_ENABLE: rdata_d = 32'(en_q);
				OFF_STATE: rdata_d = {29'h0, ds_cond, sif.done};
				OFF_ZC_SELECT: rdata_d = {30'h0, zc_select_q};
				OFF_SAG_CYC: rdata_d = 32'(sag_lim_q);
				OFF_SURGE_CYC: rdata_d = 32'(surge_lim_q);
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			cfg_q <= CONFIG_RESET;
			zc_select_q <= ZC_SELECT_RESET;
			sag_lim_q <= CYC_W'(CYC_LIMIT_RESET);
			surge_lim_q <= CYC_W'(CYC_LIMIT_RESET);
			en_q <= IRQ_RESET;
			soft_rst_q <= 1'b0;
			accclr_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			cfg_q <= cfg_d;
			zc_select_q <= zc_select_d;
			sag_lim_q <= sag_lim_d;
			surge_lim_q <= surge_lim_d;
			en_q <= en_d;
			soft_rst_q <= soft_rst_d; // R11
			accclr_q <= accclr_d; // R6
		end
	end

	assign software_reset_trigger = soft_rst_q; // R10
	assign pulse_accumulator_clear = accclr_q; // R5

	// ------------------------------------------------------------
	// Settling timer
	// ------------------------------------------------------------
	assign sif.restart = soft_rst_q; // R13
	assign sif.code = cfg_q[SETTLE_LSB +: 2]; // R4

	mcc_settle_timer #(
		.T0_CYC(T0_CYC),
		.T1_CYC(T1_CYC),
		.T2_CYC(T2_CYC),
		.CNT_W(SETTLE_CNT_W)
	) u_settle (
		.clk(clk),
		.reset(reset),
		.sif(sif)
	);

	assign accumulate_enable = sif.done; // R13

	// ------------------------------------------------------------
	// Sag and surge event generation
	// ------------------------------------------------------------
	assign ds_mode = cfg_q[BIT_DS_MODE]; // R1

	for (genvar ch = 0; ch < 2; ch++) begin : g_ds
		logic cond;
		logic cond_q, cond_d;
		logic [CYC_W-1:0] cnt_q, cnt_d;
		logic [CYC_W-1:0] lim;
		logic hit;

		assign cond = (ch == 0) ? sag_active : surge_active;
		assign lim = (ch == 0) ? sag_lim_q : surge_lim_q;
		assign hit = (lim == '0) || (cnt_q >= lim - CYC_W'(1));

		always_comb begin
			cond_d = cond;
			cnt_d = cnt_q;
			if (!cond) begin
				cnt_d = '0;
			end else if (line_cycle) begin
				cnt_d = hit ? '0 : cnt_q + CYC_W'(1); // R2
			end
		end

		always_ff @(posedge clk) begin
			if (reset || soft_rst_q) begin
				cond_q <= 1'b0;
				cnt_q <= '0;
			end else begin
				cond_q <= cond_d;
				cnt_q <= cnt_d;
			end
		end

		assign ds_evt[ch] = ds_mode ? (cond ^ cond_q) // R3
			: (cond & line_cycle & hit); // R2
		assign ds_cond[ch] = cond_q;
	end

	// ------------------------------------------------------------
	// Interrupt status, enable and output
	// ------------------------------------------------------------
	always_comb begin
		evt = '0;
		evt[IRQ_SAG] = ds_evt[0];
		evt[IRQ_SURGE] = ds_evt[1];
		evt[IRQ_SETTLED] = sif.done & ~done_prev_q;
		status_d = (status_q & ~clr_mask) | evt;
		if (soft_rst_q) begin
			status_d = IRQ_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			status_q <= IRQ_RESET;
			done_prev_q <= 1'b0;
		end else begin
			status_q <= status_d;
			done_prev_q <= sif.done;
		end
	end

	assign irq = |(status_q & en_q);

	// ------------------------------------------------------------
	// Pulse pin routing
	// ------------------------------------------------------------
	always_comb begin
		if (cfg_q[BIT_PIN3_SRC]) begin
			pin3_d = zero_cross_in[zc_select_q]; // R9
		end else begin
			pin3_d = pin_three_dfc_pulse & sif.done; // R8 R13
		end
		case (mcc_pin4_e'(cfg_q[PIN4_LSB +: 2]))
			PIN4_DFC_A: pin4_d = pin_four_dfc_pulse & sif.done; // R7
			PIN4_DFC_B: pin4_d = pin_four_dfc_pulse & sif.done; // R7
			PIN4_EVENT: pin4_d = event_indicator; // R7
			PIN4_READY: pin4_d = sample_ready_indicator; // R7
			default: pin4_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pin3_q <= 1'b0;
			pin4_q <= 1'b0;
		end else begin
			pin3_q <= pin3_d;
			pin4_q <= pin4_d;
		end
	end

	assign pulse_pin_three = pin3_q;
	assign pulse_pin_four = pin4_q;

endmodule // mcc_config_top

// ==== common/mcc_pkg.sv ====
package mcc_pkg;

	// ------------------------------------------------------------
	// Clock and settling times
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned SETTLE_T0_MS = 64;
	localparam int unsigned SETTLE_T1_MS = 128;
	localparam int unsigned SETTLE_T2_MS = 256;
	localparam int unsigned SETTLE_T0_CYC = SETTLE_T0_MS * CYC_PER_MS;
	localparam int unsigned SETTLE_T1_CYC = SETTLE_T1_MS * CYC_PER_MS;
	localparam int unsigned SETTLE_T2_CYC = SETTLE_T2_MS * CYC_PER_MS;
	localparam int unsigned SETTLE_CNT_W = 24;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'h08;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h0c;
	localparam logic [7:0] OFF_STATE = 8'h10;
	localparam logic [7:0] OFF_ZC_SELECT = 8'h14;
	localparam logic [7:0] OFF_SAG_CYC = 8'h18;
	localparam logic [7:0] OFF_SURGE_CYC = 8'h1c;

	// ------------------------------------------------------------
	// Configuration register fields
	// ------------------------------------------------------------
	localparam int unsigned BIT_SOFT_RST = 0;
	localparam int unsigned BIT_PIN3_SRC = 1;
	localparam int unsigned PIN4_LSB = 2;
	localparam int unsigned BIT_ACC_CLR = 5;
	localparam int unsigned SETTLE_LSB = 8;
	localparam int unsigned BIT_DS_MODE = 10;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	localparam logic [15:0] CONFIG_WMASK = 16'h070e;

	// ------------------------------------------------------------
	// Interrupt bits and other reset values
	// ------------------------------------------------------------
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_SAG = 0;
	localparam int unsigned IRQ_SURGE = 1;
	localparam int unsigned IRQ_SETTLED = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
	localparam logic [1:0] ZC_SELECT_RESET = 2'h0;
	localparam logic [15:0] CYC_LIMIT_RESET = 16'h0001;

	typedef enum logic [1:0] {
		PIN4_DFC_A = 2'b00,
		PIN4_DFC_B = 2'b01,
		PIN4_EVENT = 2'b10,
		PIN4_READY = 2'b11
	} mcc_pin4_e;

	typedef enum logic [1:0] {
		SETTLE_64 = 2'b00,
		SETTLE_128 = 2'b01,
		SETTLE_256 = 2'b10,
		SETTLE_NONE = 2'b11
	} mcc_settle_e;

	typedef enum logic {
		ST_COUNT = 1'b0,
		ST_DONE = 1'b1
	} mcc_settle_state_e;

endpackage

// ==== common/mcc_settle_if.sv ====
`timescale 1ns/1ps
interface mcc_settle_if;
	logic restart;
	logic [1:0] code;
	logic done;
	modport ctrl(output restart, output code, input done);
	modport timer(input restart, input code, output done);
endinterface

// ==== src/mcc_settle_timer.sv ====
`timescale 1ns/1ps
module mcc_settle_timer #(
	parameter int unsigned T0_CYC = mcc_pkg::SETTLE_T0_CYC,
	parameter int unsigned T1_CYC = mcc_pkg::SETTLE_T1_CYC,
	parameter int unsigned T2_CYC = mcc_pkg::SETTLE_T2_CYC,
	parameter int unsigned CNT_W = mcc_pkg::SETTLE_CNT_W
) (
	input wire logic clk,
	input wire logic reset,
	mcc_settle_if.timer sif
);
	import mcc_pkg::*;

	mcc_settle_state_e st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] lim;

	// ------------------------------------------------------------
	// Delay selection
	// ------------------------------------------------------------
	always_comb begin
		case (mcc_settle_e'(sif.code))
			SETTLE_64: lim = CNT_W'(T0_CYC); // R4
			SETTLE_128: lim = CNT_W'(T1_CYC); // R4
			SETTLE_256: lim = CNT_W'(T2_CYC); // R4
			default: lim = CNT_W'(1);
		endcase
	end

	// ------------------------------------------------------------
	// Count up after any reset
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			ST_COUNT: begin
				if (sif.code == SETTLE_NONE || cnt_q >= lim - CNT_W'(1)) begin
					st_d = ST_DONE; // R4
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			ST_DONE: begin
				st_d = ST_DONE;
			end
			default: begin
				st_d = ST_COUNT;
			end
		endcase
		if (sif.restart) begin
			st_d = ST_COUNT; // R13
			cnt_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_q <= ST_COUNT; // R13
			cnt_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end

	assign sif.done = (st_q == ST_DONE);

endmodule // mcc_settle_timer

// ==== tb/mcc_asserts.sv ====
`timescale 1ns/1ps
module mcc_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic pin_three_dfc_pulse,
	input wire logic pin_four_dfc_pulse,
	input wire logic event_indicator,
	input wire logic sample_ready_indicator,
	input wire logic pulse_pin_three,
	input wire logic pulse_pin_four,
	input wire logic accumulate_enable,
	input wire logic pulse_accumulator_clear,
	input wire logic software_reset_trigger
);
	// ------------------------------------------------------------
	// Shadow of the low configuration nibble, bits 3:0
	// ------------------------------------------------------------
	logic wr_ok;
	logic [3:0] cfg_q;
	assign wr_ok = avs_write && !avs_waitrequest &&
		avs_address[7:2] == 6'h00 && avs_byteenable[0];
	always_ff @(posedge clk) begin
		if (reset || software_reset_trigger)
			cfg_q <= 4'h0;
		else if (wr_ok)
			cfg_q <= avs_writedata[3:0];
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	AST_WAIT_ONE: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	AST_ACC_CLR: assert property (
		wr_ok && avs_writedata[5] |=> pulse_accumulator_clear)
		else $error("clear pulse missing");
	AST_ACC_CLR_CAUSE: assert property (
		pulse_accumulator_clear |-> $past(wr_ok && avs_writedata[5]))
		else $error("clear pulse without write");
	AST_SOFT_RST: assert property (
		wr_ok && avs_writedata[0] |=> software_reset_trigger)
		else $error("soft reset pulse missing");
	AST_SOFT_RST_SELF: assert property (
		software_reset_trigger |=> !software_reset_trigger &&
		!accumulate_enable)
		else $error("soft reset pulse stuck");
	AST_SETTLE_RESTART: assert property (disable iff (1'b0)
		reset |=> !accumulate_enable)
		else $error("accumulation on during reset");
	AST_PIN3: assert property (
		!cfg_q[1] |=> pulse_pin_three ==
		$past(pin_three_dfc_pulse && accumulate_enable))
		else $error("pin three source wrong");
	AST_PIN4: assert property (
		1'b1 |=> pulse_pin_four == $past(cfg_q[3] ?
		(cfg_q[2] ? sample_ready_indicator : event_indicator) :
		pin_four_dfc_pulse && accumulate_enable))
		else $error("pin four source wrong");
endmodule // mcc_asserts

bind mcc_config_top mcc_asserts i_chk (.clk, .reset, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_waitrequest, .pin_three_dfc_pulse, .pin_four_dfc_pulse,
	.event_indicator,
	.sample_ready_indicator, .pulse_pin_three, .pulse_pin_four,
	.accumulate_enable, .pulse_accumulator_clear, .software_reset_trigger);

// ==== tb/metering_config_control_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module metering_config_control_tb;
	logic clk, reset, avs_read, avs_write, avs_waitrequest, irq, x;
	logic line_cycle, sag_active, surge_active, accumulate_enable;
	logic pin_three_dfc_pulse, pin_four_dfc_pulse, event_indicator;
	logic sample_ready_indicator, pulse_pin_three, pulse_pin_four;
	logic pulse_accumulator_clear, software_reset_trigger;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, r, d;
	logic [3:0] avs_byteenable, zero_cross_in;
	int failures = 0;
	int checks = 0;
	int seed = 25046;
	int since = 0;
	int k, n, lo;

	mcc_config_top #(.T0_CYC(20), .T1_CYC(40), .T2_CYC(80)) i_dut (.clk,
		.reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .line_cycle,
		.sag_active, .surge_active, .pin_three_dfc_pulse,
		.pin_four_dfc_pulse,
		.event_indicator, .sample_ready_indicator, .zero_cross_in,
		.pulse_pin_three, .pulse_pin_four, .accumulate_enable,
		.pulse_accumulator_clear, .software_reset_trigger, .irq);

	// ------------------------------------------------------------
	// Clock, random pin sources, cycles since reset
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		{pin_three_dfc_pulse, pin_four_dfc_pulse, event_indicator,
			sample_ready_indicator, zero_cross_in} <= 8'($random(seed));
		since <= reset ? 0 : since + 1;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	function automatic logic [31:0] exp_cfg(input logic [31:0] v);
		return v & 32'h0000070e;
	endfunction
	function automatic int exp_settle(input int code);
		return (code == 3) ? 1 : (20 << code);
	endfunction
	task automatic conclude;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin
			failures++;
			conclude();
		end
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic lc(input int cnt);
		repeat (cnt) begin
			line_cycle <= 1'b1;
			@(posedge clk);
			line_cycle <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic hrst;
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		reset = 1'b1;
		{avs_read, avs_write, line_cycle, sag_active, surge_active} = 5'h00;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		hrst();
		bus(1'b0, 8'h00, 32'h0);
		`CHK(r, 32'h0)
		$display("reset values done");
		for (k = 0; k < 16; k++) begin
			d = $random(seed) & 32'h0000fff0 | ((k % 8) << 1);
			bus(1'b1, 8'h00, d);
			bus(1'b0, 8'h00, 32'h0);
			`CHK(r, exp_cfg(d))
			repeat (3) @(posedge clk);
		end
		$display("config fields done");
		bus(1'b1, 8'h00, 32'h2);
		for (k = 0; k < 4; k++) begin
			bus(1'b1, 8'h14, k);
			@(posedge clk);
			x = zero_cross_in[k];
			@(posedge clk);
			`CHK(pulse_pin_three, x)
		end
		$display("zero crossing done");
		bus(1'b1, 8'h00, 32'h0000030f);
		bus(1'b0, 8'h00, 32'h0);
		`CHK(r, 32'h0)
		bus(1'b0, 8'h14, 32'h0);
		`CHK(r, 32'h0)
		$display("soft reset done");
		for (k = 0; k < 4; k++) begin
			hrst();
			bus(1'b1, 8'h00, k << 8);
			lo = exp_settle(k);
			n = 0;
			while (accumulate_enable !== 1'b1 && n < 200) begin
				@(posedge clk);
				n++;
			end
			if (n >= 200) begin
				failures++;
				conclude();
			end
			`CHK(since >= lo && since <= lo + 4, 1'b1)
		end
		bus(1'b0, 8'h04, 32'h0);
		`CHK(r[2], 1'b1)
		bus(1'b0, 8'h10, 32'h0);
		`CHK(r[0], 1'b1)
		bus(1'b1, 8'h1c, 32'h2);
		bus(1'b0, 8'h1c, 32'h0);
		`CHK(r, 32'h2)
		$display("settling done");
		bus(1'b1, 8'h18, 32'h3);
		bus(1'b1, 8'h0c, 32'h3);
		bus(1'b1, 8'h08, 32'h7);
		sag_active <= 1'b1;
		lc(2);
		bus(1'b0, 8'h04, 32'h0);
		`CHK(r[1:0], 2'b00)
		lc(1);
		bus(1'b0, 8'h04, 32'h0);
		`CHK(r[1:0], 2'b01)
		`CHK(irq, 1'b1)
		bus(1'b1, 8'h08, 32'h1);
		lc(3);
		bus(1'b0, 8'h04, 32'h0);
		`CHK(r[1:0], 2'b01)
		bus(1'b1, 8'h0c, 32'h0);
		`CHK(irq, 1'b0)
		bus(1'b1, 8'h0c, 32'h3);
		bus(1'b1, 8'h00, 32'h400);
		bus(1'b1, 8'h08, 32'h7);
		lc(4);
		bus(1'b0, 8'h04, 32'h0);
		`CHK(r[1:0], 2'b00)
		sag_active <= 1'b0;
		surge_active <= 1'b1;
		repeat (2) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0);
		`CHK(r[1:0], 2'b11)
		bus(1'b1, 8'h08, 32'h3);
		lc(4);
		bus(1'b0, 8'h04, 32'h0);
		`CHK(r[1:0], 2'b00)
		$display("interrupt styles done");
		conclude();
	end
endmodule // metering_config_control_tb
